// ===== agc_cs_pkg.sv
package agc_cs_pkg;

	// ----------------------------------------------------------------
	// register map
	// ----------------------------------------------------------------
	localparam logic [5:0] GAIN_LIMITS_AND_TARGET_ADDR = 6'h1B;
	localparam logic [5:0] GAIN_ORDER_AND_BUSY_THRESHOLDS_ADDR = 6'h1C;
	localparam logic [7:0] GAIN_LIMITS_AND_TARGET_RST = 8'h03;
	localparam logic [7:0] GAIN_ORDER_AND_BUSY_THRESHOLDS_RST = 8'h40;
	localparam logic [7:0] GAIN_ORDER_AND_BUSY_THRESHOLDS_MASK = 8'h7F;

	// ----------------------------------------------------------------
	// field positions
	// ----------------------------------------------------------------
	localparam int DIGITAL_GAIN_CAP_MSB = 7;
	localparam int DIGITAL_GAIN_CAP_LSB = 6;
	localparam int FRONT_GAIN_CAP_MSB = 5;
	localparam int FRONT_GAIN_CAP_LSB = 3;
	localparam int AMPLITUDE_TARGET_MSB = 2;
	localparam int AMPLITUDE_TARGET_LSB = 0;
	localparam int GAIN_REDUCE_ORDER_BIT = 6;
	localparam int BUSY_RELATIVE_THRESHOLD_MSB = 5;
	localparam int BUSY_RELATIVE_THRESHOLD_LSB = 4;
	localparam int BUSY_ABSOLUTE_THRESHOLD_MSB = 3;
	localparam int BUSY_ABSOLUTE_THRESHOLD_LSB = 0;

	// ----------------------------------------------------------------
	// gain model and decision constants
	// ----------------------------------------------------------------
	localparam logic [2:0] GAIN_STEP_MAX = 3'h7;
	localparam logic [4:0] FRONT_REDUCTION_MAX = 5'h0E;
	localparam logic [4:0] TOTAL_REDUCTION_MAX = 5'h15;
	localparam logic [9:0] GAIN_STEP_DB = 10'h003;
	localparam logic [8:0] HYSTERESIS_DB = 9'h002;
	localparam logic [3:0] ABS_THRESHOLD_OFF = 4'h8;

	// amplitude target in dB per code
	function automatic logic [7:0] target_db(input logic [2:0] code);
		logic [7:0] t;
		t = 8'h18;
		case (code)
			3'h0: t = 8'h18;
			3'h1: t = 8'h1B;
			3'h2: t = 8'h1E;
			3'h3: t = 8'h21;
			3'h4: t = 8'h24;
			3'h5: t = 8'h26;
			3'h6: t = 8'h28;
			default: t = 8'h2A;
		endcase
		return t;
	endfunction

	// rise in dB for the relative check, 0 means disabled
	function automatic logic [9:0] rel_rise_db(input logic [1:0] code);
		logic [9:0] d;
		d = 10'h000;
		case (code)
			2'h1: d = 10'h006;
			2'h2: d = 10'h00A;
			2'h3: d = 10'h00E;
			default: d = 10'h000;
		endcase
		return d;
	endfunction

	typedef enum logic [2:0] {
		ADJ_HOLD = 3'b001,
		ADJ_DOWN = 3'b010,
		ADJ_UP = 3'b100
	} adjust_t;

endpackage

// ===== agc_gain_limit_carrier_sense.sv
`timescale 1ns/10ps
// How it works
// (RL1) digital gain cap excludes top 0-3 steps
// (RL2) front gain cap lowers combined front ceiling
// (RL3) loop drives averaged amplitude toward target
// (RL4) target code picks 24..42 dB, reset 3
// (RL5) order bit: stage one first, else two
// (RL6) relative busy on 6/10/14 dB rise, 0 off
// (RL7) absolute busy threshold signed dB around target
// (RL8) absolute code 1000 disables absolute sensing
// (RL9) absolute scale is amplitude at starting gain
// (RL10) reserved top bit reads zero, writes ignored
module agc_gain_limit_carrier_sense
	import agc_cs_pkg::*;
(
	// clock and reset
	input wire logic CLOCK_I,
	input wire logic RST_B_I,
	// register port
	input wire logic [5:0] REG_ADDR_I,
	input wire logic REG_WR_I,
	input wire logic [7:0] REG_WDATA_I,
	input wire logic REG_RD_I,
	output logic [7:0] REG_RDATA_O,
	// channel filter amplitude
	input wire logic AMP_VALID_I,
	input wire logic [7:0] AMP_DB_I,
	// gain stage settings and carrier sense
	output logic [2:0] DIGITAL_GAIN_O,
	output logic [2:0] FIRST_FRONT_GAIN_O,
	output logic [2:0] SECOND_FRONT_GAIN_O,
	output logic CARRIER_SENSE_O
);

	// ----------------------------------------------------------------
	// registers
	// ----------------------------------------------------------------
	logic [7:0] limits_r;
	logic [7:0] thresholds_r;
	logic [7:0] rdata_r;
	wire sel_limits = (REG_ADDR_I == GAIN_LIMITS_AND_TARGET_ADDR);
	wire sel_thresholds = (REG_ADDR_I == GAIN_ORDER_AND_BUSY_THRESHOLDS_ADDR);
	wire [7:0] rdata_nxt = sel_limits ? limits_r :
		(sel_thresholds ? (thresholds_r & GAIN_ORDER_AND_BUSY_THRESHOLDS_MASK) : 8'h00); // [RL10]

	always_ff @(posedge CLOCK_I or negedge RST_B_I) begin
		if (!RST_B_I) begin
			limits_r <= GAIN_LIMITS_AND_TARGET_RST; // [RL4]
			thresholds_r <= GAIN_ORDER_AND_BUSY_THRESHOLDS_RST;
			rdata_r <= 8'h00;
		end else begin
			if (REG_WR_I && sel_limits) begin
				limits_r <= REG_WDATA_I;
			end
			if (REG_WR_I && sel_thresholds) begin
				thresholds_r <= REG_WDATA_I & GAIN_ORDER_AND_BUSY_THRESHOLDS_MASK; // [RL10]
			end
			if (REG_RD_I) begin
				rdata_r <= rdata_nxt;
			end
		end
	end

	wire [1:0] digital_gain_cap = limits_r[DIGITAL_GAIN_CAP_MSB:DIGITAL_GAIN_CAP_LSB];
	wire [2:0] front_gain_cap = limits_r[FRONT_GAIN_CAP_MSB:FRONT_GAIN_CAP_LSB];
	wire [2:0] amplitude_target = limits_r[AMPLITUDE_TARGET_MSB:AMPLITUDE_TARGET_LSB];
	wire gain_reduce_order = thresholds_r[GAIN_REDUCE_ORDER_BIT];
	wire [1:0] busy_relative_threshold = thresholds_r[BUSY_RELATIVE_THRESHOLD_MSB:BUSY_RELATIVE_THRESHOLD_LSB];
	wire [3:0] busy_absolute_threshold = thresholds_r[BUSY_ABSOLUTE_THRESHOLD_MSB:BUSY_ABSOLUTE_THRESHOLD_LSB];

	// ----------------------------------------------------------------
	// gain state and limits
	// ----------------------------------------------------------------
	logic [2:0] dg_r;
	logic [2:0] s1_r;
	logic [2:0] s2_r;
	logic [2:0] dg_nxt;
	logic [2:0] s1_nxt;
	logic [2:0] s2_nxt;
	adjust_t adj;

	wire [7:0] target = target_db(amplitude_target); // [RL4]
	wire [2:0] dg_max = GAIN_STEP_MAX - {1'b0, digital_gain_cap}; // [RL1]
	wire [4:0] front_red = FRONT_REDUCTION_MAX - {2'b00, s1_r} - {2'b00, s2_r};
	wire [4:0] total_red = front_red + {2'b00, GAIN_STEP_MAX - dg_r};
	// front ceiling is enforced ahead of the loop so a new cap bites at once
	wire front_over = (front_red < {2'b00, front_gain_cap}); // [RL2]
	wire amp_hi = ({1'b0, AMP_DB_I} > ({1'b0, target} + HYSTERESIS_DB)); // [RL3]
	wire amp_lo = ({1'b0, AMP_DB_I} + HYSTERESIS_DB < {1'b0, target}); // [RL3]
	wire front_floor = (s1_r == 3'h0) && (s2_r == 3'h0);
	wire front_room = (front_red > {2'b00, front_gain_cap});

	always_comb begin
		adj = ADJ_HOLD;
		if (front_over || (AMP_VALID_I && amp_hi)) begin
			adj = ADJ_DOWN;
		end else if (AMP_VALID_I && amp_lo) begin
			adj = ADJ_UP;
		end
	end

	always_comb begin
		dg_nxt = (dg_r > dg_max) ? dg_max : dg_r; // [RL1]
		s1_nxt = s1_r;
		s2_nxt = s2_r;
		case (adj)
			ADJ_DOWN: begin
				if (!front_floor) begin
					// order picks which front stage gives way first
					if (gain_reduce_order ? (s1_r != 3'h0) : (s2_r == 3'h0)) begin // [RL5]
						s1_nxt = s1_r - 3'h1;
					end else begin
						s2_nxt = s2_r - 3'h1;
					end
				end else if (dg_nxt != 3'h0 && !front_over) begin
					dg_nxt = dg_nxt - 3'h1;
				end
			end
			ADJ_UP: begin
				if (dg_r < dg_max) begin
					dg_nxt = dg_r + 3'h1;
				end else if (front_room) begin
					// restore in the reverse of the reduction order
					if (gain_reduce_order ? (s2_r == GAIN_STEP_MAX) : (s1_r != GAIN_STEP_MAX)) begin // [RL5]
						s1_nxt = s1_r + 3'h1;
					end else begin
						s2_nxt = s2_r + 3'h1;
					end
				end
			end
			default: begin
			end
		endcase
	end

	always_ff @(posedge CLOCK_I or negedge RST_B_I) begin
		if (!RST_B_I) begin
			dg_r <= GAIN_STEP_MAX;
			s1_r <= GAIN_STEP_MAX;
			s2_r <= GAIN_STEP_MAX;
		end else begin
			dg_r <= dg_nxt; // [RL3]
			s1_r <= s1_nxt;
			s2_r <= s2_nxt;
		end
	end

	// ----------------------------------------------------------------
	// carrier sense
	// ----------------------------------------------------------------
	logic abs_hit_r;
	logic rel_hit_r;
	logic cs_r;
	logic [9:0] base_r;

	// amplitude referred back to the starting gain
	wire [9:0] amp_ref = {2'b00, AMP_DB_I} + GAIN_STEP_DB * {5'h00, total_red}; // [RL9]
	wire [9:0] abs_thr = {2'b00, target} + {{6{busy_absolute_threshold[3]}}, busy_absolute_threshold}; // [RL7]
	wire abs_on = (busy_absolute_threshold != ABS_THRESHOLD_OFF); // [RL8]
	wire [9:0] rel_rise = rel_rise_db(busy_relative_threshold);
	wire rel_on = (busy_relative_threshold != 2'h0); // [RL6]
	// one extra bit so the idle baseline cannot wrap into a false rise
	wire rel_up = ({1'b0, amp_ref} >= ({1'b0, base_r} + {1'b0, rel_rise}));

	always_ff @(posedge CLOCK_I or negedge RST_B_I) begin
		if (!RST_B_I) begin
			abs_hit_r <= 1'b0;
			rel_hit_r <= 1'b0;
			base_r <= 10'h3FF;
		end else begin
			if (!abs_on) begin
				abs_hit_r <= 1'b0; // [RL8]
			end else if (AMP_VALID_I) begin
				abs_hit_r <= (amp_ref >= abs_thr); // [RL7]
			end
			if (!rel_on) begin
				rel_hit_r <= 1'b0; // [RL6]
				base_r <= 10'h3FF;
			end else if (AMP_VALID_I) begin
				rel_hit_r <= rel_up; // [RL6]
				if (!rel_up) begin
					base_r <= amp_ref;
				end
			end
		end
	end

	// combined flag registered once more so the output is a plain flop
	always_ff @(posedge CLOCK_I or negedge RST_B_I) begin
		if (!RST_B_I) begin
			cs_r <= 1'b0;
		end else begin
			cs_r <= abs_hit_r | rel_hit_r;
		end
	end

	assign REG_RDATA_O = rdata_r;
	assign DIGITAL_GAIN_O = dg_r;
	assign FIRST_FRONT_GAIN_O = s1_r;
	assign SECOND_FRONT_GAIN_O = s2_r;
	assign CARRIER_SENSE_O = cs_r;

	// ----------------------------------------------------------------
	// checks
	// ----------------------------------------------------------------
	AST_DIGITAL_CAP: assert property (@(posedge CLOCK_I) disable iff (!RST_B_I) // [RL1]
		(dg_r > dg_max) |=> (dg_r <= $past(dg_max)))
		else $error("digital gain above its cap");

	AST_FRONT_CAP: assert property (@(posedge CLOCK_I) disable iff (!RST_B_I) // [RL2]
		front_over |=> (front_red == $past(front_red) + 5'h01))
		else $error("front gain over cap not reduced");

	AST_LOOP_DOWN: assert property (@(posedge CLOCK_I) disable iff (!RST_B_I) // [RL3]
		(AMP_VALID_I && amp_hi && !front_over && (total_red < TOTAL_REDUCTION_MAX) && !(dg_r > dg_max))
		|=> (total_red == $past(total_red) + 5'h01))
		else $error("gain not lowered on high amplitude");

	AST_TARGET_TABLE: assert property (@(posedge CLOCK_I) disable iff (!RST_B_I) // [RL4]
		(amplitude_target == 3'h5) |-> (target == 8'h26))
		else $error("amplitude target code 5 not 38 dB");

	AST_ORDER_FIRST: assert property (@(posedge CLOCK_I) disable iff (!RST_B_I) // [RL5]
		(adj == ADJ_DOWN && gain_reduce_order && s1_r != 3'h0)
		|=> (s1_r == $past(s1_r) - 3'h1) && $stable(s2_r))
		else $error("first stage not reduced first");

	AST_ORDER_SECOND: assert property (@(posedge CLOCK_I) disable iff (!RST_B_I) // [RL5]
		(adj == ADJ_DOWN && !gain_reduce_order && s2_r != 3'h0)
		|=> (s2_r == $past(s2_r) - 3'h1) && $stable(s1_r))
		else $error("second stage not reduced first");

	AST_REL_OFF: assert property (@(posedge CLOCK_I) disable iff (!RST_B_I) // [RL6]
		(!rel_on) |=> !rel_hit_r)
		else $error("relative sense active while disabled");

	AST_ABS_LEVEL: assert property (@(posedge CLOCK_I) disable iff (!RST_B_I) // [RL7]
		(AMP_VALID_I && abs_on && amp_ref >= abs_thr) |=> abs_hit_r ##1 cs_r)
		else $error("absolute threshold crossing missed");

	AST_ABS_OFF: assert property (@(posedge CLOCK_I) disable iff (!RST_B_I) // [RL8]
		(busy_absolute_threshold == ABS_THRESHOLD_OFF) |=> !abs_hit_r)
		else $error("absolute sense active with code 1000");

	AST_ABS_SCALE: assert property (@(posedge CLOCK_I) disable iff (!RST_B_I) // [RL9]
		(total_red == 5'h00) |-> (amp_ref == {2'b00, AMP_DB_I}))
		else $error("scale wrong at starting gain");

	AST_RESERVED_BIT: assert property (@(posedge CLOCK_I) disable iff (!RST_B_I) // [RL10]
		(REG_RD_I && sel_thresholds) |=> !REG_RDATA_O[7])
		else $error("reserved bit read as one");

	AST_DIGITAL_CEILING: assert property (@(posedge CLOCK_I) disable iff (!RST_B_I) // [RL1]
		!(REG_WR_I && sel_limits) && (dg_r <= dg_max) |=> (dg_r <= dg_max))
		else $error("digital gain rose above its cap");

	AST_FRONT_HELD: assert property (@(posedge CLOCK_I) disable iff (!RST_B_I) // [RL2]
		!(REG_WR_I && sel_limits) && !front_over |=> !front_over)
		else $error("front gain restored above its cap");

	AST_LOOP_UP: assert property (@(posedge CLOCK_I) disable iff (!RST_B_I) // [RL3]
		(AMP_VALID_I && amp_lo && !front_over && (dg_r < dg_max))
		|=> (dg_r == $past(dg_r) + 3'h1))
		else $error("digital gain not raised on low amplitude");

	AST_LOOP_HOLD: assert property (@(posedge CLOCK_I) disable iff (!RST_B_I) // [RL3]
		(AMP_VALID_I && !amp_hi && !amp_lo && !front_over && (dg_r <= dg_max))
		|=> $stable(dg_r) && $stable(s1_r) && $stable(s2_r))
		else $error("gain moved inside the dead zone");

	AST_IDLE_HOLD: assert property (@(posedge CLOCK_I) disable iff (!RST_B_I) // [RL3]
		(!AMP_VALID_I && !front_over && (dg_r <= dg_max))
		|=> $stable(dg_r) && $stable(s1_r) && $stable(s2_r))
		else $error("gain moved without a sample");

	AST_TARGET_LOW: assert property (@(posedge CLOCK_I) disable iff (!RST_B_I) // [RL4]
		(amplitude_target == 3'h0) |-> (target == 8'h18))
		else $error("amplitude target code 0 not 24 dB");

	AST_TARGET_HIGH: assert property (@(posedge CLOCK_I) disable iff (!RST_B_I) // [RL4]
		(amplitude_target == 3'h7) |-> (target == 8'h2A))
		else $error("amplitude target code 7 not 42 dB");

	AST_ORDER_FIRST_EMPTY: assert property (@(posedge CLOCK_I) disable iff (!RST_B_I) // [RL5]
		(adj == ADJ_DOWN && gain_reduce_order && s1_r == 3'h0 && s2_r != 3'h0)
		|=> (s2_r == $past(s2_r) - 3'h1) && $stable(s1_r))
		else $error("second stage not reduced after first empty");

	AST_ORDER_SECOND_EMPTY: assert property (@(posedge CLOCK_I) disable iff (!RST_B_I) // [RL5]
		(adj == ADJ_DOWN && !gain_reduce_order && s2_r == 3'h0 && s1_r != 3'h0)
		|=> (s1_r == $past(s1_r) - 3'h1) && $stable(s2_r))
		else $error("first stage not reduced after second empty");

	AST_REL_RISE: assert property (@(posedge CLOCK_I) disable iff (!RST_B_I) // [RL6]
		(AMP_VALID_I && rel_on && rel_up) |=> rel_hit_r ##1 cs_r)
		else $error("relative rise missed");

	AST_REL_QUIET: assert property (@(posedge CLOCK_I) disable iff (!RST_B_I) // [RL6]
		(AMP_VALID_I && rel_on && !rel_up) |=> !rel_hit_r)
		else $error("relative sense without a rise");

	AST_ABS_BELOW: assert property (@(posedge CLOCK_I) disable iff (!RST_B_I) // [RL7]
		(AMP_VALID_I && abs_on && (amp_ref < abs_thr)) |=> !abs_hit_r)
		else $error("absolute sense below threshold");

	AST_CS_OFF: assert property (@(posedge CLOCK_I) disable iff (!RST_B_I) // [RL8]
		(!rel_on && !abs_on) |=> ##1 !cs_r)
		else $error("carrier sense with both checks disabled");

	AST_RESERVED_HELD: assert property (@(posedge CLOCK_I) disable iff (!RST_B_I) // [RL10]
		!thresholds_r[7])
		else $error("reserved bit stored as one");

endmodule

// ===== agc_gain_limit_carrier_sense_test.sv
`timescale 1ns/10ps
module agc_gain_limit_carrier_sense_test
	import agc_cs_pkg::*;
;
	// ------------------------------------------------------------
	// stimulus and bookkeeping
	// ------------------------------------------------------------
	logic clock_i = 1'b0;
	logic rst_b_i = 1'b0;
	logic [5:0] addr = 6'h00;
	logic wr = 1'b0;
	logic rd = 1'b0;
	logic [7:0] wdata = 8'h00;
	logic amp_valid = 1'b0;
	logic [7:0] amp = 8'h00;
	logic [7:0] rdata;
	logic [2:0] dg, g1, g2;
	logic cs;
	int fail_count = 0;
	int total_checks = 0;
	int cycles = 0;
	logic [31:0] seed = 32'h0000_91CC;
	logic [7:0] d, t;
	int i, k;
	localparam logic [5:0] A2 = GAIN_LIMITS_AND_TARGET_ADDR;
	localparam logic [5:0] A1 = GAIN_ORDER_AND_BUSY_THRESHOLDS_ADDR;

	agc_gain_limit_carrier_sense agc_gain_limit_carrier_sense_i (
		.CLOCK_I(clock_i), .RST_B_I(rst_b_i), .REG_ADDR_I(addr), .REG_WR_I(wr), .REG_WDATA_I(wdata),
		.REG_RD_I(rd), .REG_RDATA_O(rdata), .AMP_VALID_I(amp_valid), .AMP_DB_I(amp),
		.DIGITAL_GAIN_O(dg), .FIRST_FRONT_GAIN_O(g1), .SECOND_FRONT_GAIN_O(g2), .CARRIER_SENSE_O(cs)
	);

	always #5 clock_i = ~clock_i;

	// ------------------------------------------------------------
	// helpers
	// ------------------------------------------------------------
	function automatic logic [7:0] xs();
		seed = seed ^ (seed << 13);
		seed = seed ^ (seed >> 17);
		seed = seed ^ (seed << 5);
		return seed[7:0];
	endfunction

	// target amplitude in dB for a code, worked out independently of the design
	function automatic logic [7:0] tgt(input logic [2:0] c);
		logic [7:0] tb [8];
		tb = '{8'h18, 8'h1B, 8'h1E, 8'h21, 8'h24, 8'h26, 8'h28, 8'h2A};
		return tb[c];
	endfunction

	task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string what);
		total_checks++;
		if (got !== exp) begin
			fail_count++;
			$display("[FAIL] %0t %s got %h expected %h", $time, what, got, exp);
		end
	endtask

	task automatic do_reset();
		@(posedge clock_i);
		rst_b_i <= 1'b0;
		repeat (12) @(posedge clock_i);
		rst_b_i <= 1'b1;
	endtask

	task automatic wreg(input logic [5:0] a, input logic [7:0] v);
		@(posedge clock_i);
		addr <= a;
		wdata <= v;
		wr <= 1'b1;
		@(posedge clock_i);
		wr <= 1'b0;
	endtask

	task automatic rreg(input logic [5:0] a, input logic [7:0] exp);
		@(posedge clock_i);
		addr <= a;
		rd <= 1'b1;
		@(posedge clock_i);
		rd <= 1'b0;
		#1;
		chk(rdata, exp, "register read");
	endtask

	// one amplitude sample, then carrier sense checked two cycles later
	task automatic samp(input logic [7:0] v, input logic exp_cs);
		@(posedge clock_i);
		amp <= v;
		amp_valid <= 1'b1;
		@(posedge clock_i);
		amp_valid <= 1'b0;
		repeat (2) @(posedge clock_i);
		#1;
		chk({7'h00, cs}, {7'h00, exp_cs}, "carrier sense");
	endtask

	task automatic gains(input logic [2:0] e0, input logic [2:0] e1, input logic [2:0] e2);
		chk({5'h00, dg}, {5'h00, e0}, "digital gain");
		chk({5'h00, g1}, {5'h00, e1}, "first front gain");
		chk({5'h00, g2}, {5'h00, e2}, "second front gain");
	endtask

	task automatic summarize();
		$display("checks %0d mismatches %0d", total_checks, fail_count);
		if (fail_count == 0 && total_checks > 0) begin
			$display("Finished cleanly");
		end else begin
			$display("Finished with errors");
		end
		$finish;
	endtask

	always @(posedge clock_i) begin
		cycles++;
		if (cycles == 20000) begin
			fail_count++;
			$display("[FAIL] %0t run did not finish", $time);
			summarize();
		end
	end

	// ------------------------------------------------------------
	// main sequence
	// ------------------------------------------------------------
	initial begin
		do_reset();
		rreg(A2, 8'h03);
		rreg(A1, 8'h40);
		rreg(6'h3F, 8'h00);
		for (i = 0; i < 8; i++) begin
			d = xs();
			wreg(A2, d);
			rreg(A2, d);
			wreg(A1, d | 8'h80);
			rreg(A1, d & 8'h7F);
		end
		$display("test registers done");
		// caps from full gain, corner plus random combinations
		for (i = 0; i < 6; i++) begin
			d = (i == 0) ? 8'hF8 : xs();
			k = xs() & 1;
			do_reset();
			wreg(A1, {1'b0, k[0], 6'h08});
			wreg(A2, d);
			repeat (24) @(posedge clock_i);
			#1;
			gains(3'h7 - {1'b0, d[7:6]}, k ? 3'h7 - d[5:3] : 3'h7, k ? 3'h7 : 3'h7 - d[5:3]);
		end
		$display("test gain caps done");
		do_reset();
		wreg(A1, 8'h48);
		samp(8'h24, 1'b0);
		gains(3'h7, 3'h6, 3'h7);
		samp(8'h23, 1'b0);
		gains(3'h7, 3'h6, 3'h7);
		samp(8'h1E, 1'b0);
		gains(3'h7, 3'h7, 3'h7);
		wreg(A1, 8'h08);
		samp(8'h24, 1'b0);
		gains(3'h7, 3'h7, 3'h6);
		$display("test gain loop done");
		do_reset();
		for (i = -7; i < 3; i++) begin
			d = xs();
			t = tgt(d[2:0]);
			wreg(A2, {5'h00, d[2:0]});
			wreg(A1, {4'h4, i[3:0]});
			samp(t + i[7:0], 1'b1);
			samp(t + i[7:0] - 8'h01, 1'b0);
		end
		wreg(A1, 8'h48);
		samp(t + 8'h02, 1'b0);
		// front cap forces two steps, so the threshold sits on the starting-gain scale
		wreg(A2, 8'h13);
		wreg(A1, 8'h40);
		repeat (4) @(posedge clock_i);
		#1;
		gains(3'h7, 3'h5, 3'h7);
		samp(tgt(3'h3) - 8'(GAIN_STEP_DB + GAIN_STEP_DB), 1'b1);
		samp(tgt(3'h3) - 8'(GAIN_STEP_DB + GAIN_STEP_DB) - 8'h01, 1'b0);
		$display("test absolute sense done");
		do_reset();
		wreg(A2, 8'h07);
		for (i = 1; i < 4; i++) begin
			k = 2 + 4 * i;
			wreg(A1, {2'b01, i[1:0], 4'h8});
			samp(8'h00, 1'b0);
			samp(k[7:0] - 8'h01, 1'b0);
			samp(2 * k[7:0] - 8'h01, 1'b1);
		end
		wreg(A1, 8'h48);
		samp(8'h00, 1'b0);
		samp(8'h1B, 1'b0);
		wreg(A1, 8'h78);
		samp(8'h1B, 1'b0);
		$display("test relative sense done");
		summarize();
	end
endmodule
